// File: pkg/csq_defines.vh
`ifndef CSQ_DEFINES_VH
`define CSQ_DEFINES_VH

// ----------------------------------------
// Clock
// ----------------------------------------
`define CSQ_CLK_MHZ        250

// ----------------------------------------
// Command link timing, microseconds
// ----------------------------------------
`define CSQ_T_PULSE_MIN_US 100
`define CSQ_T_PULSE_MAX_US 120
`define CSQ_T_START_MIN_US 350
`define CSQ_T_START_MAX_US 400
`define CSQ_T_STOP_MIN_US  500
`define CSQ_START_MIN_CYC  (`CSQ_T_START_MIN_US * `CSQ_CLK_MHZ)
`define CSQ_START_MAX_CYC  (`CSQ_T_START_MAX_US * `CSQ_CLK_MHZ)
`define CSQ_STOP_MIN_CYC   (`CSQ_T_STOP_MIN_US * `CSQ_CLK_MHZ)

// ----------------------------------------
// Command codes
// ----------------------------------------
`define CSQ_CMD_IEND_OFF   6'd11
`define CSQ_CMD_IEND_5     6'd12
`define CSQ_CMD_IEND_2P5   6'd13
`define CSQ_CMD_WDOG_OFF   6'd26
`define CSQ_CMD_WDOG_ON    6'd27
`define CSQ_CMD_HALF_OFF   6'd28
`define CSQ_CMD_HALF_ON    6'd29

// ----------------------------------------
// Power-on and status timing
// ----------------------------------------
`define CSQ_T_VIN_VALID_MS 250
`define CSQ_VIN_VALID_CYC  (`CSQ_T_VIN_VALID_MS * 1000 * `CSQ_CLK_MHZ)
// Status toggle rates, tenths of Hz
`define CSQ_F_CHARGE_DHZ   62
`define CSQ_F_EOC_DHZ      41
`define CSQ_F_OVCHG_DHZ    82
`define CSQ_F_TMO_DHZ      102
`define CSQ_F_LOWBAT_DHZ   128
`define CSQ_F_TWARN_DHZ    142
`define CSQ_F_NTC_DHZ      162
`define CSQ_HALF_CYC(f)    ((`CSQ_CLK_MHZ * 5000000) / (f))

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CSQ_RST_WDOG       1'b0
`define CSQ_RST_HALF       1'b0
`define CSQ_RST_IEND       2'd1

`endif

// File: hdl/csq_pulse_rx.v
`timescale 1ns/1ns
`include "csq_defines.vh"

// Pulse-count command receiver for the single wire command link
module csq_pulse_rx #(
  parameter integer START_MIN = `CSQ_START_MIN_CYC,
  parameter integer START_MAX = `CSQ_START_MAX_CYC,
  parameter integer STOP_MIN  = `CSQ_STOP_MIN_CYC
) (
  // Clock and reset
  input  wire       mclk,
  input  wire       sys_rst,
  // Synchronised link level
  input  wire       cmd_level,
  // Frame result
  output reg        cmd_valid_q,
  output reg  [5:0] cmd_count_q
);

  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_START = 2'd1;
  localparam [1:0] ST_BITS  = 2'd2;

  reg  [1:0]  state_q;
  reg  [19:0] tmr_q;
  reg  [5:0]  cnt_q;
  reg         lvl_q;
  wire        rise;
  wire        fall;

  assign rise = cmd_level & ~lvl_q;
  assign fall = ~cmd_level & lvl_q;

  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q     <= ST_IDLE;
      tmr_q       <= 20'h0;
      cnt_q       <= 6'h0;
      lvl_q       <= 1'b0;
      cmd_valid_q <= 1'b0;
      cmd_count_q <= 6'h0;
    end
    else
    begin
      lvl_q       <= cmd_level;
      cmd_valid_q <= 1'b0;
      if (rise || fall || tmr_q == 20'hfffff)
        tmr_q <= (rise || fall) ? 20'h0 : tmr_q;
      else
        tmr_q <= tmr_q + 20'h1;
      case (state_q)
        ST_IDLE:
        begin
          cnt_q <= 6'h0;
          if (rise)
            state_q <= ST_START;
        end
        ST_START:
        begin
          // Start interval is a high level of bounded length
          if (fall)
          begin
            if (tmr_q >= START_MIN - 1 && tmr_q <= START_MAX - 1)
              state_q <= ST_BITS;
            else
              state_q <= ST_IDLE;
          end
        end
        ST_BITS:
        begin
          if (rise && cnt_q != 6'h3f)
            cnt_q <= cnt_q + 6'h1;
          if (!cmd_level && tmr_q >= STOP_MIN - 1)
          begin
            cmd_valid_q <= 1'b1;
            cmd_count_q <= cnt_q;
            state_q     <= ST_IDLE;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

endmodule

// File: hdl/csq_charge_seq.v
`timescale 1ns/1ns
`include "csq_defines.vh"

module csq_charge_seq #(
  parameter integer VIN_VALID_CYC = `CSQ_VIN_VALID_CYC,
  parameter integer PRE_TMO_CYC   = 32'd100000000,
  parameter integer FAST_TMO_CYC  = 32'd100000000,
  parameter integer START_MIN     = `CSQ_START_MIN_CYC,
  parameter integer START_MAX     = `CSQ_START_MAX_CYC,
  parameter integer STOP_MIN      = `CSQ_STOP_MIN_CYC
) (
  // Clock and reset
  input  wire       mclk,
  input  wire       sys_rst,
  // Analog comparator pins
  input  wire       vin_valid,
  input  wire       bat_above_3v,
  input  wire       wake_up,
  input  wire       bat_above_precharge,
  input  wire       bat_at_float,
  input  wire       ichg_below_end,
  input  wire       bat_overcharge,
  input  wire       temp_in_range,
  input  wire       thermal_warning,
  input  wire       ifast_above_20ma,
  // Control pins
  input  wire       charger_enable_input,
  input  wire       immediate_reset_input,
  input  wire       pulse_command_input,
  // Supply and regulation
  output reg        supply_enable_q,
  output reg        precharge_on_q,
  output reg        fastcharge_on_q,
  output reg        cv_mode_q,
  output reg        input_path_closed_q,
  output reg        half_current_q,
  output reg  [1:0] iend_sel_q,
  output reg        watchdog_mode_q,
  output reg        reset_clear_q,
  output reg        temp_monitor_on_q,
  // Open-drain status flag
  output wire       charge_status_flag_o,
  output wire       charge_status_flag_oe_n
);

  localparam [2:0] ST_OFF   = 3'd0;
  localparam [2:0] ST_PRE   = 3'd1;
  localparam [2:0] ST_FAST  = 3'd2;
  localparam [2:0] ST_CV    = 3'd3;
  localparam [2:0] ST_EOC   = 3'd4;
  localparam [2:0] ST_STOP  = 3'd5;
  localparam [2:0] ST_OVCHG = 3'd6;

  localparam integer NIN = 13;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  wire [NIN-1:0] raw_in;
  reg  [NIN-1:0] sync1_q;
  reg  [NIN-1:0] sync2_q;

  assign raw_in = {pulse_command_input, immediate_reset_input, charger_enable_input,
                   ifast_above_20ma, thermal_warning, temp_in_range, bat_overcharge,
                   ichg_below_end, bat_at_float, bat_above_precharge, wake_up,
                   bat_above_3v, vin_valid};

  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi = gi + 1)
    begin : g_sync
      always @(posedge mclk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end
        else
        begin
          sync1_q[gi] <= raw_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  wire s_vin   = sync2_q[0];
  wire s_b3v   = sync2_q[1];
  wire s_wake  = sync2_q[2];
  wire s_bpre  = sync2_q[3];
  wire s_flt   = sync2_q[4];
  wire s_iend  = sync2_q[5];
  wire s_ovc   = sync2_q[6];
  wire s_tok   = sync2_q[7];
  wire s_twarn = sync2_q[8];
  wire s_i20   = sync2_q[9];
  wire s_cen   = sync2_q[10];
  wire s_rnow  = sync2_q[11];
  wire s_cmd   = sync2_q[12];

  // ----------------------------------------
  // Command receiver and option bits
  // ----------------------------------------
  wire       cmd_valid;
  wire [5:0] cmd_count;

  csq_pulse_rx #(
    .START_MIN (START_MIN),
    .START_MAX (START_MAX),
    .STOP_MIN  (STOP_MIN)
  ) u_rx (
    .mclk        (mclk),
    .sys_rst     (sys_rst),
    .cmd_level   (s_cmd),
    .cmd_valid_q (cmd_valid),
    .cmd_count_q (cmd_count)
  );

  reg half_cmd_q;

  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      watchdog_mode_q <= `CSQ_RST_WDOG;
      half_cmd_q      <= `CSQ_RST_HALF;
      iend_sel_q      <= `CSQ_RST_IEND;
    end
    else if (cmd_valid)
    begin
      case (cmd_count)
        `CSQ_CMD_WDOG_OFF: watchdog_mode_q <= 1'b0;
        `CSQ_CMD_WDOG_ON:  watchdog_mode_q <= 1'b1;
        `CSQ_CMD_HALF_OFF: half_cmd_q <= 1'b0;
        `CSQ_CMD_HALF_ON:  half_cmd_q <= 1'b1;
        `CSQ_CMD_IEND_OFF: iend_sel_q <= 2'd0;
        `CSQ_CMD_IEND_5:   iend_sel_q <= 2'd1;
        `CSQ_CMD_IEND_2P5: iend_sel_q <= 2'd2;
        default:           iend_sel_q <= iend_sel_q;
      endcase
    end
  end

  // ----------------------------------------
  // Power-on qualification
  // ----------------------------------------
  reg [31:0] vin_cnt_q;
  wire       vin_ok = (vin_cnt_q >= VIN_VALID_CYC - 1);

  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      vin_cnt_q       <= 32'h0;
      supply_enable_q <= 1'b0;
    end
    else
    begin
      if (!s_vin)
        vin_cnt_q <= 32'h0;
      else if (!vin_ok)
        vin_cnt_q <= vin_cnt_q + 32'h1;
      if (s_vin && vin_ok)
        supply_enable_q <= 1'b1;
      else if (!s_vin && s_b3v && s_wake)
        supply_enable_q <= 1'b1;
      else if (!s_vin && !s_b3v)
        supply_enable_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Charge sequencer
  // ----------------------------------------
  reg [2:0]  state_q;
  reg [31:0] tmr_q;
  reg        cen_q;
  reg        tmo_fault_q;
  reg        low_fault_q;
  reg        ntc_alarm_q;
  wire       cen_rise = s_cen & ~cen_q;
  wire       charging = (state_q == ST_PRE) || (state_q == ST_FAST) || (state_q == ST_CV);
  wire       temp_bad = charging & ~s_tok;
  wire       tmo_pre  = (state_q == ST_PRE) && (tmr_q >= PRE_TMO_CYC - 1);
  wire       tmo_fast = (state_q == ST_FAST) && (tmr_q >= FAST_TMO_CYC - 1);

  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q     <= ST_OFF;
      tmr_q       <= 32'h0;
      cen_q       <= 1'b0;
      tmo_fault_q <= 1'b0;
      low_fault_q <= 1'b0;
      ntc_alarm_q <= 1'b0;
    end
    else
    begin
      cen_q       <= s_cen;
      ntc_alarm_q <= temp_bad;
      if (state_q == ST_PRE || state_q == ST_FAST)
        tmr_q <= tmr_q + 32'h1;
      if (!s_vin)
      begin
        state_q     <= ST_OFF;
        tmo_fault_q <= 1'b0;
        low_fault_q <= 1'b0;
      end
      else if (s_ovc && state_q != ST_OVCHG)
        state_q <= ST_OVCHG;
      else
      begin
        case (state_q)
          ST_OFF:
          begin
            tmr_q <= 32'h0;
            if (s_cen)
              state_q <= s_bpre ? ST_FAST : ST_PRE;
          end
          ST_PRE:
          begin
            if (!s_cen)
              state_q <= ST_STOP;
            else if (tmo_pre)
            begin
              state_q     <= ST_STOP;
              tmo_fault_q <= 1'b1;
            end
            else if (s_bpre)
            begin
              state_q <= ST_FAST;
              tmr_q   <= 32'h0;
            end
          end
          ST_FAST:
          begin
            if (!s_cen)
              state_q <= ST_STOP;
            else if (tmo_fast)
            begin
              state_q     <= ST_STOP;
              tmo_fault_q <= 1'b1;
            end
            else if (!s_bpre)
            begin
              state_q     <= ST_STOP;
              low_fault_q <= 1'b1;
            end
            else if (s_flt)
              state_q <= ST_CV;
          end
          ST_CV:
          begin
            if (!s_cen)
              state_q <= ST_STOP;
            else if (s_iend && iend_sel_q != 2'd0 && !temp_bad)
              state_q <= ST_EOC;
          end
          ST_EOC, ST_STOP:
          begin
            if (cen_rise)
            begin
              state_q     <= ST_OFF;
              tmo_fault_q <= 1'b0;
              low_fault_q <= 1'b0;
            end
          end
          ST_OVCHG:
            state_q <= ST_OVCHG;
          default:
            state_q <= ST_OFF;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Charger outputs
  // ----------------------------------------
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      precharge_on_q      <= 1'b0;
      fastcharge_on_q     <= 1'b0;
      cv_mode_q           <= 1'b0;
      input_path_closed_q <= 1'b0;
      half_current_q      <= 1'b0;
      temp_monitor_on_q   <= 1'b0;
      reset_clear_q       <= 1'b0;
    end
    else
    begin
      precharge_on_q      <= (state_q == ST_PRE) && !temp_bad;
      fastcharge_on_q     <= (state_q == ST_FAST) && !temp_bad;
      cv_mode_q           <= (state_q == ST_CV) && !temp_bad;
      input_path_closed_q <= s_vin && (state_q != ST_OVCHG);
      half_current_q      <= half_cmd_q | s_twarn;
      temp_monitor_on_q   <= charging;
      reset_clear_q       <= watchdog_mode_q & s_rnow;
    end
  end

  // ----------------------------------------
  // Status flag divider
  // ----------------------------------------
  reg [31:0] half_per;
  reg        toggling;

  always @*
  begin
    toggling = 1'b1;
    half_per = 32'd0;
    if (!s_vin)
      toggling = 1'b0;
    else if (ntc_alarm_q)
      half_per = `CSQ_HALF_CYC(`CSQ_F_NTC_DHZ);
    else if (charging && s_twarn)
      half_per = `CSQ_HALF_CYC(`CSQ_F_TWARN_DHZ);
    else if (low_fault_q)
      half_per = `CSQ_HALF_CYC(`CSQ_F_LOWBAT_DHZ);
    else if (tmo_fault_q)
      half_per = `CSQ_HALF_CYC(`CSQ_F_TMO_DHZ);
    else if (state_q == ST_OVCHG)
      half_per = `CSQ_HALF_CYC(`CSQ_F_OVCHG_DHZ);
    else if (charging)
      half_per = `CSQ_HALF_CYC(`CSQ_F_CHARGE_DHZ);
    else if (state_q == ST_EOC)
      half_per = `CSQ_HALF_CYC(`CSQ_F_EOC_DHZ);
    else
      toggling = 1'b0;
  end

  reg [31:0] div_q;
  reg        phase_q;
  reg        flag_low_q;

  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_q      <= 32'h0;
      phase_q    <= 1'b0;
      flag_low_q <= 1'b0;
    end
    else
    begin
      if (!toggling)
      begin
        div_q   <= 32'h0;
        phase_q <= 1'b0;
      end
      else if (div_q >= half_per - 1)
      begin
        div_q   <= 32'h0;
        phase_q <= ~phase_q;
      end
      else
        div_q <= div_q + 32'h1;
      flag_low_q <= s_vin && (!toggling || !phase_q);
    end
  end

  assign charge_status_flag_o    = 1'b0;
  assign charge_status_flag_oe_n = ~flag_low_q;

endmodule

// File: test/csq_charge_seq_sva.sv
`timescale 1ns/1ns
module csq_charge_seq_sva (
  // Clock and reset
  input wire mclk,
  input wire sys_rst,
  // Watched inputs
  input wire vin_valid,
  input wire bat_overcharge,
  input wire temp_in_range,
  input wire thermal_warning,
  input wire charger_enable_input,
  // Watched outputs
  input wire precharge_on_q,
  input wire fastcharge_on_q,
  input wire input_path_closed_q,
  input wire half_current_q,
  input wire watchdog_mode_q,
  input wire reset_clear_q,
  input wire temp_monitor_on_q,
  input wire charge_status_flag_o,
  input wire charge_status_flag_oe_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------
  // Input held long enough to pass the sync
  // ----------------------------------------
  sequence held6(s);
    s [*6];
  endsequence

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  half_forced_a: assert property (held6(thermal_warning) |-> half_current_q)
    else $error("half current not forced by thermal warning");
  clear_wdog_a: assert property (reset_clear_q |-> $past(watchdog_mode_q))
    else $error("reset clear active without watchdog mode");
  one_phase_a: assert property (!(precharge_on_q && fastcharge_on_q))
    else $error("pre-charge and fast charge both on");
  ovchg_open_a: assert property (held6(vin_valid && bat_overcharge) |-> !input_path_closed_q)
    else $error("input path closed during overcharge");
  novin_idle_a: assert property (held6(!vin_valid)
    |-> !precharge_on_q && !fastcharge_on_q && charge_status_flag_oe_n)
    else $error("charging or flag driven without input supply");
  novin_notemp_a: assert property (held6(!vin_valid) |-> !temp_monitor_on_q)
    else $error("temperature monitor on without input supply");
  hot_pause_a: assert property (held6(!temp_in_range) |-> !precharge_on_q && !fastcharge_on_q)
    else $error("charging while temperature out of range");
  cen_off_a: assert property (held6(!charger_enable_input)
    |-> !precharge_on_q && !fastcharge_on_q)
    else $error("charging while charger disabled");
  flag_low_a: assert property (!charge_status_flag_oe_n
    |-> !charge_status_flag_o && $past(vin_valid, 3))
    else $error("status flag driven badly or without input supply");
endmodule

bind csq_charge_seq csq_charge_seq_sva csq_charge_seq_sva_i (.*);

// File: test/csq_host_model.sv
`timescale 1ns/1ns
module csq_host_model (
  // Clock
  input wire mclk,
  // Command link
  output reg line
);
  initial line = 1'b0;

  // ----------------------------------------
  // One frame: start, n pulses, stop
  // ----------------------------------------
  task send_frame(input integer hi, input [5:0] n);
    integer i;
    @(posedge mclk) #1 line = 1'b1;
    repeat (hi) @(posedge mclk);
    #1 line = 1'b0;
    for (i = 0; i < n; i = i + 1)
    begin
      repeat (10) @(posedge mclk);
      #1 line = 1'b1;
      repeat (10) @(posedge mclk);
      #1 line = 1'b0;
    end
    repeat (60) @(posedge mclk);
  endtask

  // Frame with a start interval inside the window
  task send(input [5:0] n);
    send_frame(38, n);
  endtask
endmodule

// File: test/tb_charge_sequencer_with_pulse_commands.sv
`timescale 1ns/1ns
module tb_charge_sequencer_with_pulse_commands;
  logic mclk, sys_rst, vin_valid, bat_above_3v, wake_up, bat_above_precharge;
  logic bat_at_float, ichg_below_end, bat_overcharge, temp_in_range, thermal_warning;
  logic ifast_above_20ma, charger_enable_input, immediate_reset_input;
  wire  pulse_command_input, supply_enable_q, precharge_on_q, fastcharge_on_q, cv_mode_q;
  wire  input_path_closed_q, half_current_q, watchdog_mode_q, reset_clear_q;
  wire  temp_monitor_on_q, charge_status_flag_o, charge_status_flag_oe_n;
  wire  [1:0] iend_sel_q;
  int   errors, n_checks;
  logic [5:0] cmds [8] = '{6'h1b, 6'h1d, 6'h1c, 6'h0d, 6'h0b, 6'h28, 6'h0c, 6'h1a};
  logic [3:0] opts [8] = '{4'h9, 4'hd, 4'h9, 4'ha, 4'h8, 4'h8, 4'h9, 4'h1};

  csq_charge_seq #(.VIN_VALID_CYC(100), .PRE_TMO_CYC(1000), .FAST_TMO_CYC(1000),
    .START_MIN(35), .STOP_MIN(50)) csq_charge_seq_i (.*);
  csq_host_model csq_host_model_i (.mclk(mclk), .line(pulse_command_input));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task cyc(input integer n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t flag got %b exp %b", $time, got, exp);
    end
  endtask
  task chk4(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t options got %h exp %h", $time, got, exp);
    end
  endtask
  task cen_cycle;
    charger_enable_input = 1'b0;
    cyc(10);
    charger_enable_input = 1'b1;
    cyc(10);
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_power;
    chk4({watchdog_mode_q, half_current_q, iend_sel_q}, 4'h1);
    chk1(charge_status_flag_oe_n, 1'b1);
    vin_valid = 1'b1;
    cyc(50);
    chk1(supply_enable_q, 1'b0);
    cyc(70);
    chk1(supply_enable_q, 1'b1);
    chk1(precharge_on_q, 1'b1);
    chk1(charge_status_flag_oe_n, 1'b0);
    cyc(1050);
    chk1(precharge_on_q, 1'b0);
    cen_cycle;
    chk1(precharge_on_q, 1'b1);
    $display("test power done");
  endtask
  task t_phases;
    bat_above_precharge = 1'b1;
    cyc(10);
    chk1(fastcharge_on_q, 1'b1);
    bat_above_precharge = 1'b0;
    cyc(10);
    chk1(fastcharge_on_q | precharge_on_q, 1'b0);
    bat_above_precharge = 1'b1;
    cen_cycle;
    chk1(fastcharge_on_q, 1'b1);
    bat_at_float = 1'b1;
    cyc(10);
    chk1(cv_mode_q, 1'b1);
    ichg_below_end = 1'b1;
    cyc(10);
    chk1(cv_mode_q, 1'b0);
    $display("test phases done");
  endtask
  task t_temp;
    bat_at_float = 1'b0;
    ichg_below_end = 1'b0;
    cen_cycle;
    chk1(temp_monitor_on_q, 1'b1);
    temp_in_range = 1'b0;
    cyc(10);
    chk1(fastcharge_on_q, 1'b0);
    temp_in_range = 1'b1;
    cyc(10);
    chk1(fastcharge_on_q, 1'b1);
    temp_in_range = 1'b0;
    cyc(1000);
    temp_in_range = 1'b1;
    cyc(10);
    chk1(fastcharge_on_q, 1'b0);
    cen_cycle;
    chk1(fastcharge_on_q, 1'b1);
    $display("test temperature done");
  endtask
  task t_cmds;
    immediate_reset_input = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      csq_host_model_i.send(cmds[i]);
      cyc(10);
      chk4({watchdog_mode_q, half_current_q, iend_sel_q}, opts[i]);
      chk1(reset_clear_q, opts[i][3]);
    end
    // Start interval too short: frame must be dropped
    csq_host_model_i.send_frame(20, 6'h1b);
    cyc(10);
    chk4({watchdog_mode_q, half_current_q, iend_sel_q}, 4'h1);
    thermal_warning = 1'b1;
    cyc(10);
    chk1(half_current_q, 1'b1);
    thermal_warning = 1'b0;
    cyc(10);
    chk1(half_current_q, 1'b0);
    $display("test commands done");
  endtask
  task t_ovchg;
    chk1(input_path_closed_q, 1'b1);
    bat_overcharge = 1'b1;
    cyc(10);
    chk1(input_path_closed_q, 1'b0);
    bat_overcharge = 1'b0;
    cen_cycle;
    chk1(input_path_closed_q, 1'b0);
    vin_valid = 1'b0;
    cyc(10);
    vin_valid = 1'b1;
    cyc(120);
    chk1(input_path_closed_q, 1'b1);
    $display("test overcharge done");
  endtask
  task t_batt;
    vin_valid = 1'b0;
    cyc(10);
    chk1(supply_enable_q, 1'b0);
    bat_above_3v = 1'b1;
    wake_up = 1'b1;
    cyc(10);
    wake_up = 1'b0;
    cyc(5);
    chk1(supply_enable_q, 1'b1);
    chk1(temp_monitor_on_q, 1'b0);
    $display("test battery done");
  endtask

  // ----------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial
  begin
    repeat (100000) @(posedge mclk);
    errors++;
    $display("ERROR %0t run did not finish", $time);
    give_verdict;
  end
  initial
  begin
    {vin_valid, bat_above_3v, wake_up, bat_above_precharge, bat_at_float} = 5'h00;
    {ichg_below_end, bat_overcharge, thermal_warning, immediate_reset_input} = 4'h0;
    {temp_in_range, ifast_above_20ma, charger_enable_input} = 3'h7;
    errors = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    cyc(5);
    sys_rst = 1'b0;
    t_power;
    t_phases;
    t_temp;
    t_cmds;
    t_ovchg;
    t_batt;
    give_verdict;
  end
endmodule
